// ---- rtl/tioc_consts.svh ----
// constants of the terminal i/o controller command logic: offsets, fields, timing
// assumes a 250 MHz system clock and an axi4-lite register bus
// Behaviour
// - phase generator runs on system clock; master clear forces it stopped
// - idle generator holds all phases low and stays idle
// - generator starts only on write command while terminal selected
// - start stage, then phase one, two, three, then stop
// - reply or reject comes 0.2 to 10 us after write command
// - reply enable needs write, director bit, and function bit 1-5, 11 or 14
// - otherwise reject; reply and reject never together (an unselected write gets neither, as the generator never starts)
// - reply also needs terminal select active
// - response flip-flop set after phase three issues reply or reject
// - function bit 9 asks write mode, bit 10 asks read mode
// - write, director bit and write function set mode flop at phase three
// - read function without write function leaves mode flop clear
// - write mode: next output moves character cpu to terminal
// - read mode: next moves received character or status to cpu
// - frame one start, seven or eight data, one stop; two at 110 baud
// - program mode owns terminal; panel mode hands it to breakpoint controller
// - escape and bell switch ownership and are not passed as data
// - address 0091 selects function or status, 0090 selects data
`ifndef TIOC_CONSTS_SVH
`define TIOC_CONSTS_SVH
`define TIOC_CLK_MHZ 250
`define TIOC_RESP_MIN_NS 200
`define TIOC_RESP_MIN_CYC ((`TIOC_RESP_MIN_NS * `TIOC_CLK_MHZ + 999) / 1000)
`define TIOC_GEN_MHZ_X10K 49152
`define TIOC_GEN_DIV ((`TIOC_CLK_MHZ * 10000) / `TIOC_GEN_MHZ_X10K)
`define TIOC_ADDR_DATA 16'h0090
`define TIOC_ADDR_FUNC 16'h0091
`define TIOC_REG_ADDR 8'h00
`define TIOC_REG_FUNC 8'h04
`define TIOC_REG_CMD 8'h08
`define TIOC_REG_STATUS 8'h0c
`define TIOC_REG_CHAR 8'h10
`define TIOC_FN_WRITE 9
`define TIOC_FN_READ 10
`define TIOC_FN_REPLY_MASK 16'h483e
`define TIOC_ESC 8'h1b
`define TIOC_BEL 8'h07
`endif

// ---- rtl/tioc_pkg.sv ----
// types of the terminal i/o controller command logic
// assumes tioc_consts.svh is included by the design files
package tioc_pkg;
    typedef enum logic [4:0] {
        TIOC_IDLE = 5'h01,
        TIOC_START = 5'h02,
        TIOC_PH1 = 5'h04,
        TIOC_PH2 = 5'h08,
        TIOC_PH3 = 5'h10
    } tioc_phase_e;
endpackage : tioc_pkg

// ---- rtl/tioc_phase_gen.sv ----
// three-phase timing generator stepped by a divided-clock enable
// assumes start is a same-domain level held until the generator runs
`timescale 1ns/1ns
`include "tioc_consts.svh"
module tioc_phase_gen
    import tioc_pkg::*;
(
    // clock and clear
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic master_clear,
    // control
    input wire logic start,
    // phases
    output logic phase_one,
    output logic phase_two,
    output logic phase_three,
    output logic done
);
    typedef struct packed {
        logic [7:0] div;
        tioc_phase_e st;
        logic p1;
        logic p2;
        logic p3;
        logic dn;
    } tioc_gen_s;
    tioc_gen_s q, next_q;
    logic tick;
    always_comb begin
        next_q = q;
        next_q.dn = 1'b0;
        tick = (q.div == 8'(`TIOC_GEN_DIV - 1));
        next_q.div = tick ? 8'h00 : q.div + 8'h01;
        if (tick) begin
            case (q.st)
                TIOC_IDLE: if (start) next_q.st = TIOC_START;
                TIOC_START: next_q.st = TIOC_PH1;
                TIOC_PH1: next_q.st = TIOC_PH2;
                TIOC_PH2: next_q.st = TIOC_PH3;
                TIOC_PH3: begin
                    next_q.st = TIOC_IDLE;
                    next_q.dn = 1'b1;
                end
                default: next_q.st = TIOC_IDLE;
            endcase
        end
        next_q.p1 = (next_q.st == TIOC_PH1);
        next_q.p2 = (next_q.st == TIOC_PH2);
        next_q.p3 = (next_q.st == TIOC_PH3);
    end
    always_ff @(posedge clock) begin
        if (sys_rst || master_clear) begin
            q <= '{div: 8'h00, st: TIOC_IDLE, p1: 1'b0, p2: 1'b0, p3: 1'b0, dn: 1'b0};
        end else begin
            q <= next_q;
        end
    end
    assign phase_one = q.p1;
    assign phase_two = q.p2;
    assign phase_three = q.p3;
    assign done = q.dn;
endmodule : tioc_phase_gen

// ---- rtl/tioc_ctrl.sv ----
// terminal i/o controller command side: channel decode, reply/reject, mode
// assumes parallel channel pins are asynchronous; software on axi4-lite
`timescale 1ns/1ns
`include "tioc_consts.svh"
module tioc_ctrl
    import tioc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // parallel channel from the cpu memory interface
    input wire logic master_clear,
    input wire logic write_cmd,
    input wire logic [15:0] address_in,
    input wire logic [15:0] function_in,
    output logic reply,
    output logic reject,
    // mode and ownership
    output logic write_mode_flag,
    output logic read_mode_flag,
    output logic panel_mode,
    output logic data_strobe,
    output logic [7:0] data_char,
    output logic two_stop_bits,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef struct packed {
        logic [1:0] wr_sync;
        logic [1:0] mc_sync;
        logic [31:0] a_sync;
        logic [31:0] f_sync;
        logic [15:0] addr_reg;
        logic [15:0] func_reg;
        logic resp_ff;
        logic reply_dec;
        logic reply;
        logic reject;
        logic mode_ff;
        logic panel;
        logic slow_line;
        logic dstb;
        logic [7:0] dchar;
        logic [7:0] rx_char;
        logic [7:0] last_ctl;
        logic awr;
        logic wr;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tioc_ctrl_s;
    tioc_ctrl_s q, next_q;
    logic phase_one, phase_two, phase_three, gen_done;
    logic wr_cmd, term_sel, dir_bit, reply_en, mc;
    function automatic logic sel_decode(input logic [15:0] a);
        sel_decode = (a[15:1] == 15'(`TIOC_ADDR_DATA >> 1));
    endfunction : sel_decode
    always_comb begin
        wr_cmd = q.wr_sync[1];
        mc = q.mc_sync[1];
        term_sel = sel_decode(q.a_sync[31:16]);
        dir_bit = q.a_sync[16];
        reply_en = wr_cmd && dir_bit && ((q.f_sync[31:16] & `TIOC_FN_REPLY_MASK) != 16'h0000);
    end
    tioc_phase_gen u_gen (
        .clock(clock),
        .sys_rst(sys_rst),
        .master_clear(mc),
        .start(wr_cmd && term_sel && !q.resp_ff),
        .phase_one(phase_one),
        .phase_two(phase_two),
        .phase_three(phase_three),
        .done(gen_done)
    );
    always_comb begin
        next_q = q;
        next_q.wr_sync = {q.wr_sync[0], write_cmd};
        next_q.mc_sync = {q.mc_sync[0], master_clear};
        next_q.a_sync = {q.a_sync[15:0], address_in};
        next_q.f_sync = {q.f_sync[15:0], function_in};
        next_q.dstb = 1'b0;
        if (phase_one) begin
            next_q.addr_reg = q.a_sync[31:16];
            next_q.func_reg = q.f_sync[31:16];
            next_q.reply_dec = reply_en && term_sel;
        end
        if (phase_three && dir_bit && wr_cmd) begin
            if (q.func_reg[`TIOC_FN_WRITE]) begin
                next_q.mode_ff = 1'b1;
            end else if (q.func_reg[`TIOC_FN_READ]) begin
                next_q.mode_ff = 1'b0;
            end
        end
        // phase three lasts a whole tick; the end pulse moves one character only
        if (gen_done && !dir_bit && q.mode_ff && !q.panel) begin
            // escape and bell never leave as data
            if (q.func_reg[7:0] == `TIOC_ESC || q.func_reg[7:0] == `TIOC_BEL) begin
                next_q.panel = (q.func_reg[7:0] == `TIOC_ESC);
            end else begin
                next_q.dstb = 1'b1;
                next_q.dchar = q.func_reg[7:0];
            end
        end
        if (gen_done) begin
            next_q.resp_ff = 1'b1;
            next_q.reply = q.reply_dec;
            next_q.reject = !q.reply_dec;
        end else if (!wr_cmd) begin
            // response held until the cpu drops write, then one pulse only
            next_q.resp_ff = 1'b0;
            next_q.reply = 1'b0;
            next_q.reject = 1'b0;
        end
        // axi4-lite write path
        if (s_axi_awvalid && !q.awr && !q.bvalid) begin
            next_q.awr = 1'b1;
            next_q.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.wr && !q.bvalid) begin
            next_q.wr = 1'b1;
            next_q.wdata = s_axi_wdata;
        end
        if (q.awr && q.wr) begin
            next_q.awr = 1'b0;
            next_q.wr = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = 2'b00;
            case (q.awaddr)
                `TIOC_REG_CMD: begin
                    next_q.slow_line = q.wdata[0];
                    next_q.panel = q.wdata[1];
                end
                `TIOC_REG_CHAR: begin
                    if (q.wdata[7:0] == `TIOC_ESC || q.wdata[7:0] == `TIOC_BEL) begin
                        next_q.last_ctl = q.wdata[7:0];
                        next_q.panel = (q.wdata[7:0] == `TIOC_BEL) ? 1'b0 : q.panel;
                    end else begin
                        next_q.rx_char = q.wdata[7:0];
                    end
                end
                default: next_q.bresp = 2'b10;
            endcase
        end else if (q.bvalid && s_axi_bready) begin
            next_q.bvalid = 1'b0;
        end
        // axi4-lite read path
        if (s_axi_arvalid && !q.rvalid) begin
            next_q.rvalid = 1'b1;
            next_q.rresp = 2'b00;
            case (s_axi_araddr)
                `TIOC_REG_ADDR: next_q.rdata = {16'h0000, q.addr_reg};
                `TIOC_REG_FUNC: next_q.rdata = {16'h0000, q.func_reg};
                `TIOC_REG_CMD: next_q.rdata = {30'h0, q.panel, q.slow_line};
                `TIOC_REG_STATUS: next_q.rdata = {24'h0, q.last_ctl[0], q.resp_ff,
                    q.reply_dec, !q.mode_ff, q.mode_ff, phase_three, phase_two, phase_one};
                `TIOC_REG_CHAR: next_q.rdata = {24'h0, q.mode_ff ? 8'h00 : q.rx_char};
                default: begin
                    next_q.rdata = 32'h0;
                    next_q.rresp = 2'b10;
                end
            endcase
        end else if (q.rvalid && s_axi_rready) begin
            next_q.rvalid = 1'b0;
        end
        // master clear overrides what the command logic would do to the mode flop, response flop, reply and reject
        if (mc) begin
            next_q.mode_ff = 1'b0;
            next_q.resp_ff = 1'b0;
            next_q.reply = 1'b0;
            next_q.reject = 1'b0;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
    assign reply = q.reply;
    assign reject = q.reject;
    assign write_mode_flag = q.mode_ff;
    assign read_mode_flag = !q.mode_ff;
    assign panel_mode = q.panel;
    assign data_strobe = q.dstb;
    assign data_char = q.dchar;
    assign two_stop_bits = q.slow_line;
    assign s_axi_awready = !q.awr && !q.bvalid;
    assign s_axi_wready = !q.wr && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
endmodule : tioc_ctrl

// ---- sim/tioc_ctrl_properties.sv ----
// concurrent checks on the command side of the terminal i/o controller
// assumes it is bound to tioc_ctrl and sees only its ports
`timescale 1ns/1ns
`include "tioc_consts.svh"
module tioc_ctrl_properties (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // channel
    input wire logic write_cmd,
    input wire logic [15:0] address_in,
    input wire logic [15:0] function_in,
    input wire logic reply,
    input wire logic reject,
    // mode
    input wire logic write_mode_flag,
    input wire logic read_mode_flag,
    input wire logic data_strobe
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic sel;
    logic fn_hit;
    logic [11:0] wait_cnt;
    assign sel = address_in[15:1] == 15'h0048;
    assign fn_hit = |(function_in & `TIOC_FN_REPLY_MASK);
    // an unselected write is never answered, so only selected ones are timed
    always_ff @(posedge clock) begin
        if (sys_rst || !write_cmd || !sel || reply || reject) begin
            wait_cnt <= 12'h000;
        end else begin
            wait_cnt <= wait_cnt + 12'h001;
        end
    end
    property p_excl; !(reply && reject); endproperty
    a_excl: assert property (p_excl) else $error("reply with reject");
    property p_modes; write_mode_flag != read_mode_flag; endproperty
    a_modes: assert property (p_modes) else $error("mode flags agree");
    property p_min; $rose(reply || reject) |-> $past(write_cmd, 50); endproperty
    a_min: assert property (p_min) else $error("answer too early");
    property p_max; wait_cnt < 12'h9c4; endproperty
    a_max: assert property (p_max) else $error("answer too late");
    property p_reply; $rose(reply) |-> sel && address_in[0] && fn_hit; endproperty
    a_reply: assert property (p_reply) else $error("reply not enabled");
    property p_reject; $rose(reject) |-> sel && !(address_in[0] && fn_hit); endproperty
    a_reject: assert property (p_reject) else $error("reject wrongly");
    property p_clear; !write_cmd [*8] |-> !reply && !reject; endproperty
    a_clear: assert property (p_clear) else $error("answer stuck");
    property p_wmode; $rose(write_mode_flag) |-> address_in[0] && function_in[9]; endproperty
    a_wmode: assert property (p_wmode) else $error("write mode wrongly");
    property p_strobe; data_strobe |=> !data_strobe; endproperty
    a_strobe: assert property (p_strobe) else $error("strobe too long");
    c_reply: cover property ($rose(reply));
    c_reject: cover property ($rose(reject));
    c_wmode: cover property ($rose(write_mode_flag));
endmodule : tioc_ctrl_properties
bind tioc_ctrl tioc_ctrl_properties u_props (.clock, .sys_rst, .write_cmd, .address_in,
    .function_in, .reply, .reject, .write_mode_flag, .read_mode_flag, .data_strobe);

// ---- sim/tioc_cpu_model.sv ----
// cpu side of the parallel channel: loads address and function, then writes
// assumes the controller answers with reply or reject levels
`timescale 1ns/1ns
module tioc_cpu_model (
    // clock
    input wire logic clock,
    // channel
    output logic master_clear,
    output logic write_cmd,
    output logic [15:0] address_in,
    output logic [15:0] function_in,
    input wire logic reply,
    input wire logic reject
);
    initial begin
        master_clear = 1'b0;
        write_cmd = 1'b0;
        address_in = 16'h0000;
        function_in = 16'h0000;
    end
    // resp is {reply, reject}; 2'b00 means the cpu made its own reject
    task automatic xfer(input logic [15:0] a, input logic [15:0] f,
            output logic [1:0] resp, output int n);
        @(posedge clock);
        address_in <= a;
        function_in <= f;
        @(posedge clock);
        write_cmd <= 1'b1;
        for (n = 0; n < 3250 && !(reply || reject); n++) @(posedge clock);
        resp = {reply, reject};
        write_cmd <= 1'b0;
        // released lines do not keep their last value
        address_in <= ~a;
        function_in <= ~f;
        repeat (20) @(posedge clock);
    endtask : xfer
    task automatic clear;
        master_clear <= 1'b1;
        repeat (4) @(posedge clock);
        master_clear <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : clear
endmodule : tioc_cpu_model

// ---- sim/tb_tioc_ctrl.sv ----
// self-checking bench for the terminal i/o controller command side
// assumes the cpu model drives the channel and this bench drives axi4-lite
`timescale 1ns/1ns
module tb_tioc_ctrl;
    logic clock, sys_rst, master_clear, write_cmd, reply, reject, write_mode_flag;
    logic read_mode_flag, two_stop_bits, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [15:0] address_in, function_in;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, got;
    logic [3:0] s_axi_wstrb;
    logic panel_mode, data_strobe;
    logic [7:0] data_char, seen_char;
    int strobes;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int failures, checks, n;
    tioc_ctrl u_dut (.clock, .sys_rst, .master_clear, .write_cmd, .address_in,
        .function_in, .reply, .reject, .write_mode_flag, .read_mode_flag,
        .panel_mode, .data_strobe, .data_char, .two_stop_bits, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    tioc_cpu_model u_cpu (.clock, .master_clear, .write_cmd, .address_in,
        .function_in, .reply, .reject);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // counts character strobes so a held strobe shows up as extra characters
    always @(posedge clock) begin
        if (data_strobe) begin
            strobes <= strobes + 1;
            seen_char <= data_char;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // values read just after an edge are the ones the design sampled at it
        for (i = 0; i < 100; i++) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // a free edge keeps the next call from reassigning bready in this step
        @(posedge clock);
        chk("write answered", 1, i < 100);
        if (i >= 100) report_and_stop();
    endtask : axw
    task automatic axr(input logic [7:0] a);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rsp = s_axi_rresp;
        got = s_axi_rdata;
        s_axi_rready <= 1'b0;
        @(posedge clock);
        chk("read answered", 1, i < 100);
        if (i >= 100) report_and_stop();
    endtask : axr
    task automatic t_reply;
        int bits[7] = '{1, 2, 3, 4, 5, 11, 14};
        for (int k = 0; k < 7; k++) begin
            u_cpu.xfer(16'h0091, 16'h0001 << bits[k], rsp, n);
            chk("reply", 2'b10, rsp);
            chk("latency", 1, n >= 50 && n <= 2500);
        end
        u_cpu.xfer(16'h0091, 16'hb7c1, rsp, n);
        chk("no function", 2'b01, rsp);
        u_cpu.xfer(16'h0090, 16'h0002, rsp, n);
        chk("no director", 2'b01, rsp);
        u_cpu.xfer(16'h0093, 16'h0002, rsp, n);
        chk("unselected", 2'b00, rsp);
        $display("test reply done");
    endtask : t_reply
    task automatic t_data;
        int k0;
        u_cpu.xfer(16'h0091, 16'h0200, rsp, n);
        k0 = strobes;
        u_cpu.xfer(16'h0090, 16'h0041, rsp, n);
        chk("strobes", 1, strobes - k0);
        chk("char", 8'h41, seen_char);
        u_cpu.xfer(16'h0090, 16'h001b, rsp, n);
        chk("esc as data", 1, strobes - k0);
        chk("panel", 1, panel_mode);
        axw(8'h10, 32'h0000_0007);
        chk("program", 0, panel_mode);
        $display("test data done");
    endtask : t_data
    task automatic t_mode;
        u_cpu.xfer(16'h0091, 16'h0200, rsp, n);
        chk("write flag", 1, write_mode_flag);
        u_cpu.xfer(16'h0091, 16'h0400, rsp, n);
        chk("read flag", 1, read_mode_flag);
        u_cpu.xfer(16'h0091, 16'h0200, rsp, n);
        u_cpu.clear();
        chk("cleared", 1, read_mode_flag);
        $display("test mode done");
    endtask : t_mode
    task automatic t_regs;
        axw(8'h08, 32'h0000_0001);
        chk("bresp", 2'b00, rsp);
        chk("two stop", 1, two_stop_bits);
        axr(8'h0c);
        chk("status read", 1, got[4]);
        axr(8'h14);
        chk("unmapped resp", 2'b10, rsp);
        chk("unmapped data", 32'h0, got);
        $display("test regs done");
    endtask : t_regs
    initial begin
        sys_rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        chk("reset mode", 2'b01, {write_mode_flag, read_mode_flag});
        chk("idle", 2'b00, {reply, reject});
        t_reply();
        t_data();
        t_mode();
        t_regs();
        report_and_stop();
    end
endmodule : tb_tioc_ctrl
